//--- inc/bridge_io_limit_pkg.sv
// Constants and carrier types for the I/O window top and secondary status
package bridge_io_limit_pkg;

	// Configuration dword that holds both registers
	localparam logic [7:0]  REG_OFFSET        = 8'h1c;

	// Byte lanes of the dword, active-low enables
	localparam int          LANE_TOP          = 1;
	localparam int          LANE_STAT_LO      = 2;
	localparam int          LANE_STAT_HI      = 3;

	// Window top byte layout (within the dword)
	localparam int          TOP_FIELD_LSB     = 12;
	localparam int          TOP_FIELD_W       = 4;
	localparam int          DECODE_CODE_LSB   = 8;
	localparam logic [3:0]  TOP_FIELD_RST     = 4'h0;
	localparam logic [3:0]  DECODE_CODE       = 4'h1;
	localparam int          WINDOW_LOW_W      = 12;
	localparam int          STATUS_LSB        = 16;

	// Secondary status halfword positions
	localparam int          POS_PARITY        = 15;
	localparam int          POS_FAR_SYSERR    = 14;
	localparam int          POS_GOT_MABORT    = 13;
	localparam int          POS_GOT_TABORT    = 12;
	localparam int          POS_SENT_TABORT   = 11;
	localparam int          POS_DEVSEL_LSB    = 9;
	localparam int          POS_MASTER_PARITY = 8;
	localparam int          POS_FBB           = 7;
	localparam int          POS_HIGH_SPEED    = 5;
	localparam int          POS_CAP_LIST      = 4;
	localparam logic [1:0]  DEVSEL_CODE       = 2'h1;
	localparam logic [15:0] STATUS_W1C_MASK   = 16'hf900;
	localparam logic [15:0] STATUS_RST        = 16'h02a0;

	// Configuration request from the primary bus
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be_n;
		logic [31:0] wdata;
	} cfg_req_type;

	// Secondary bus events, one-cycle pulses or levels
	typedef struct packed {
		logic addr_parity_err;
		logic data_parity_err;
		logic got_master_abort;
		logic got_target_abort;
		logic sent_target_abort;
		logic sec_is_master;
		logic primary_parity_err;
	} sec_event_type;

endpackage

//--- logic/sticky_flag.sv
// One write-one-to-clear status flag where a set beats a clear
`timescale 1ns/1ps
module sticky_flag (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end

endmodule

//--- logic/bridge_io_limit_secondary_status.sv
// I/O window top byte and secondary bus status register of a bridge
//
// Notes on behaviour
// - Four-bit writable window top, bits 15:12, reset zero.
// - Window top bounds forwarded I/O range.
// - Window aligned and sized in 4 KB steps.
// - Address bits 31:16 come from upper register.
// - Decode code reads 1 in bits 11:8.
// - Writing one clears a flag; zero leaves it.
// - Bit 31 sets on secondary parity error.
// - Bit 30 sets on secondary system error pin.
// - Bit 29 sets on our master abort.
// - Bit 28 sets on received target abort.
// - Bit 27 sets when we signal target abort.
// - Decode timing field reads fixed 1.
// - Bit 24 needs master, parity fault, enable.
// - Bits 23, 21 read 1; bit 20 reads 0.
// - Reserved bits 22, 19:16 read zero.
// - Status resets to 0x02a0.
`timescale 1ns/1ps
module bridge_io_limit_secondary_status (
	input  wire logic                              core_clk,
	input  wire logic                              nrst,
	input  wire bridge_io_limit_pkg::cfg_req_type  cfg_req,
	input  wire bridge_io_limit_pkg::sec_event_type sec_event,
	input  wire logic                              secondary_system_error_pin_n,
	input  wire logic                              secondary_parity_error_pin_n,
	input  wire logic                              parity_response_en,
	input  wire logic [15:0]                       io_upper_top,
	input  wire logic [31:0]                       io_window_base,
	input  wire logic [31:0]                       io_query_addr,
	output logic [31:0]                            cfg_rdata,
	output logic                                   cfg_rvalid,
	output logic [3:0]                             io_window_top_field,
	output logic [31:0]                            io_window_top_addr,
	output logic                                   io_forward_hit
);

	localparam int LIM_HI = bridge_io_limit_pkg::TOP_FIELD_LSB
		+ bridge_io_limit_pkg::TOP_FIELD_W - 1;

	logic        hit;
	logic        wr_hit;
	logic        rd_hit;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [15:0] flag_q;
	logic [15:0] status_value;
	logic [15:0] fixed_bits;
	logic        parity_fault_seen;
	logic        far_system_fault_seen;
	logic        master_parity_fault;
	logic [31:0] next_rdata;

	assign hit    = cfg_req.addr == bridge_io_limit_pkg::REG_OFFSET;
	assign wr_hit = cfg_req.wr && hit;
	assign rd_hit = cfg_req.rd && hit;

	// Window top field
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			io_window_top_field <= bridge_io_limit_pkg::TOP_FIELD_RST;
		end else if (wr_hit
			&& !cfg_req.be_n[bridge_io_limit_pkg::LANE_TOP]) begin
			io_window_top_field <= cfg_req.wdata[LIM_HI:
				bridge_io_limit_pkg::TOP_FIELD_LSB];
		end
	end

	// Forwarding window top and range check in whole 4 KB blocks
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			io_window_top_addr <= 32'h0000_0000;
			io_forward_hit     <= 1'b0;
		end else begin
			io_window_top_addr <= {io_upper_top, io_window_top_field,
				{bridge_io_limit_pkg::WINDOW_LOW_W{1'b0}}};
			io_forward_hit <= io_query_addr[31:12]
				>= io_window_base[31:12]
				&& io_query_addr[31:12]
				<= {io_upper_top, io_window_top_field};
		end
	end

	// Flag sources
	assign parity_fault_seen = sec_event.addr_parity_err
		|| sec_event.data_parity_err;
	assign far_system_fault_seen = !secondary_system_error_pin_n;
	assign master_parity_fault = sec_event.sec_is_master
		&& (!secondary_parity_error_pin_n
		|| sec_event.primary_parity_err)
		&& parity_response_en;

	always_comb begin
		flag_set = 16'h0000;
		flag_set[bridge_io_limit_pkg::POS_PARITY]     = parity_fault_seen;
		flag_set[bridge_io_limit_pkg::POS_FAR_SYSERR] = far_system_fault_seen;
		flag_set[bridge_io_limit_pkg::POS_GOT_MABORT] =
			sec_event.got_master_abort;
		flag_set[bridge_io_limit_pkg::POS_GOT_TABORT] =
			sec_event.got_target_abort;
		flag_set[bridge_io_limit_pkg::POS_SENT_TABORT] =
			sec_event.sent_target_abort;
		flag_set[bridge_io_limit_pkg::POS_MASTER_PARITY] = master_parity_fault;
	end

	// Clear per enabled lane, ones only
	always_comb begin
		flag_clr = 16'h0000;
		if (wr_hit) begin
			if (!cfg_req.be_n[bridge_io_limit_pkg::LANE_STAT_LO]) begin
				flag_clr[7:0] = cfg_req.wdata[23:16];
			end
			if (!cfg_req.be_n[bridge_io_limit_pkg::LANE_STAT_HI]) begin
				flag_clr[15:8] = cfg_req.wdata[31:24];
			end
		end
		flag_clr = flag_clr & bridge_io_limit_pkg::STATUS_W1C_MASK;
	end

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_flag
			if (bridge_io_limit_pkg::STATUS_W1C_MASK[i]) begin : g_w1c
				sticky_flag u_flag (
					.core_clk (core_clk),
					.nrst     (nrst),
					.set      (flag_set[i]),
					.clr      (flag_clr[i]),
					.q        (flag_q[i])
				);
			end else begin : g_fixed
				assign flag_q[i] = 1'b0;
			end
		end
	endgenerate

	// Fixed capability bits, reserved bits zero
	always_comb begin
		fixed_bits = 16'h0000;
		fixed_bits[bridge_io_limit_pkg::POS_DEVSEL_LSB +: 2] =
			bridge_io_limit_pkg::DEVSEL_CODE;
		fixed_bits[bridge_io_limit_pkg::POS_FBB]        = 1'b1;
		fixed_bits[bridge_io_limit_pkg::POS_HIGH_SPEED] = 1'b1;
		fixed_bits[bridge_io_limit_pkg::POS_CAP_LIST]   = 1'b0;
	end

	assign status_value = flag_q | fixed_bits;

	// Read data; base byte lives elsewhere and reads zero here
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_hit) begin
			next_rdata[bridge_io_limit_pkg::STATUS_LSB +: 16] = status_value;
			next_rdata[LIM_HI:bridge_io_limit_pkg::TOP_FIELD_LSB] =
				io_window_top_field;
			next_rdata[bridge_io_limit_pkg::DECODE_CODE_LSB +: 4] =
				bridge_io_limit_pkg::DECODE_CODE;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_rdata  <= 32'h0000_0000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rdata  <= next_rdata;
			cfg_rvalid <= cfg_req.rd;
		end
	end

	// Helper: read of this dword one cycle ago
	logic rd_hit_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_hit_q <= 1'b0;
		end else begin
			rd_hit_q <= rd_hit;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_field_write;
		wr_hit && !cfg_req.be_n[1]
			|=> io_window_top_field == $past(cfg_req.wdata[15:12]);
	endproperty
	a_field_write: assert property (p_field_write)
		else $error("window top field not written");

	property p_field_lane_off;
		!(wr_hit && !cfg_req.be_n[1]) |=> $stable(io_window_top_field);
	endproperty
	a_field_lane_off: assert property (p_field_lane_off)
		else $error("window top changed without its lane");

	property p_top_addr;
		##1 1'b1 |=> io_window_top_addr
			== {$past(io_upper_top), $past(io_window_top_field),
			12'h000};
	endproperty
	a_top_addr: assert property (p_top_addr)
		else $error("window top address wrong");

	property p_hit_block;
		io_query_addr[31:12] > {io_upper_top, io_window_top_field}
			|=> !io_forward_hit;
	endproperty
	a_hit_block: assert property (p_hit_block)
		else $error("forwarded above window top");

	property p_read_code;
		rd_hit_q |-> cfg_rvalid && cfg_rdata[11:8] == 4'h1
			&& cfg_rdata[15:12] == $past(io_window_top_field)
			&& cfg_rdata[31:16] == $past(status_value);
	endproperty
	a_read_code: assert property (p_read_code)
		else $error("read data of dword wrong");

	property p_parity_set;
		parity_fault_seen |=> flag_q[15];
	endproperty
	a_parity_set: assert property (p_parity_set)
		else $error("parity flag not set");

	property p_syserr_set;
		!secondary_system_error_pin_n |=> flag_q[14];
	endproperty
	a_syserr_set: assert property (p_syserr_set)
		else $error("system error flag not set");

	property p_aborts_set;
		sec_event.got_master_abort || sec_event.got_target_abort
			|| sec_event.sent_target_abort
			|=> (flag_q[13] || !$past(sec_event.got_master_abort))
			&& (flag_q[12] || !$past(sec_event.got_target_abort))
			&& (flag_q[11] || !$past(sec_event.sent_target_abort));
	endproperty
	a_aborts_set: assert property (p_aborts_set)
		else $error("abort flag not set");

	property p_master_parity_cause;
		$rose(flag_q[8]) |-> $past(sec_event.sec_is_master
			&& parity_response_en && (!secondary_parity_error_pin_n
			|| sec_event.primary_parity_err));
	endproperty
	a_master_parity_cause: assert property (p_master_parity_cause)
		else $error("master parity flag set without cause");

	property p_clear_one;
		wr_hit && !cfg_req.be_n[3] && cfg_req.wdata[31]
			&& !parity_fault_seen |=> !flag_q[15];
	endproperty
	a_clear_one: assert property (p_clear_one)
		else $error("flag not cleared by one");

	property p_fixed_bits;
		(status_value & 16'h06ff) == 16'h02a0;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("fixed status bits wrong");

	property p_reset_value;
		@(posedge core_clk) $rose(nrst) |-> status_value == 16'h02a0
			&& io_window_top_field == 4'h0;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("reset value wrong");

	c_clear: cover property (wr_hit && cfg_req.wdata[31] && flag_q[15]);
	c_set_vs_clear: cover property (flag_set[15] && flag_clr[15]);
	c_read: cover property (rd_hit_q);
	c_forward: cover property (io_forward_hit);

endmodule

//--- testbench/config_host.sv
// Primary bus configuration host driving the strobe port
`timescale 1ns/1ps
module config_host (
	input  wire logic                        core_clk,
	output bridge_io_limit_pkg::cfg_req_type cfg_req,
	input  wire logic [31:0]                 cfg_rdata,
	input  wire logic                        cfg_rvalid
);
	initial cfg_req = '0;

	// One-cycle write strobe; idle fields show inverted leftovers
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be_n,
		input logic [31:0] d);
		@(posedge core_clk);
		cfg_req <= '{1'b1, 1'b0, a, be_n, d};
		@(posedge core_clk);
		cfg_req <= '{1'b0, 1'b0, ~a, ~be_n, ~d};
	endtask

	// Read strobe, then a bounded wait for the answer pulse
	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
		output logic late);
		int n;
		@(posedge core_clk);
		cfg_req <= '{1'b0, 1'b1, a, 4'h0, 32'h0};
		@(posedge core_clk);
		cfg_req <= '{1'b0, 1'b0, ~a, 4'hf, 32'hffff_ffff};
		late = 1'b1;
		d = 32'h0;
		for (n = 0; n < 4 && late; n++) begin
			@(posedge core_clk);
			if (cfg_rvalid === 1'b1) begin
				d = cfg_rdata;
				late = 1'b0;
			end
		end
	endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the window top byte and secondary status
`timescale 1ns/1ps
module tb_top;
	logic                               core_clk = 1'b0;
	logic                               nrst = 1'b0;
	bridge_io_limit_pkg::cfg_req_type   cfg_req;
	bridge_io_limit_pkg::sec_event_type sec_event = '0;
	logic                               sys_n = 1'b1;
	logic                               par_n = 1'b1;
	logic                               par_en = 1'b0;
	logic [31:0]                        query = 32'h0;
	logic [15:0]                        upper = 16'h0001;
	logic [31:0]                        rdata;
	logic                               rvalid;
	logic [3:0]                         field;
	logic [31:0]                        top_addr;
	logic                               hit;
	logic [31:0]                        got;
	logic                               late;
	int                                 errors = 0;
	int                                 num_checks = 0;
	// Event, {system pin, parity pin, enable}, expected flag
	logic [6:0]  ev_tab [10] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04,
		7'h00, 7'h03, 7'h03, 7'h02, 7'h01};
	logic [2:0]  pin_tab [10] = '{3'b110, 3'b110, 3'b110, 3'b110, 3'b110,
		3'b010, 3'b111, 3'b110, 3'b101, 3'b111};
	logic [15:0] exp_tab [10] = '{16'h8000, 16'h8000, 16'h2000, 16'h1000,
		16'h0800, 16'h4000, 16'h0100, 16'h0000, 16'h0100, 16'h0000};
	logic [31:0] q_tab [4] = '{32'h0001_4ff0, 32'h0001_5000,
		32'h0001_2000, 32'h0001_1fff};
	logic        hit_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	always #2 core_clk = ~core_clk;

	config_host config_host_i (
		.core_clk   (core_clk),
		.cfg_req    (cfg_req),
		.cfg_rdata  (rdata),
		.cfg_rvalid (rvalid)
	);

	bridge_io_limit_secondary_status bridge_io_limit_secondary_status_i (
		.core_clk                     (core_clk),
		.nrst                         (nrst),
		.cfg_req                      (cfg_req),
		.sec_event                    (sec_event),
		.secondary_system_error_pin_n (sys_n),
		.secondary_parity_error_pin_n (par_n),
		.parity_response_en           (par_en),
		.io_upper_top                 (upper),
		.io_window_base               (32'h0001_2000),
		.io_query_addr                (query),
		.cfg_rdata                    (rdata),
		.cfg_rvalid                   (rvalid),
		.io_window_top_field          (field),
		.io_window_top_addr           (top_addr),
		.io_forward_hit               (hit)
	);

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		config_host_i.cfg_read(a, got, late);
		if (late) begin
			errors++;
			$display("wrong value at %0t: read never answered", $time);
			complete_run();
		end else begin
			check(got, exp);
		end
	endtask

	// One-cycle event with pin levels, then idle again
	task automatic fire(input logic [6:0] ev, input logic [2:0] pins);
		@(posedge core_clk);
		sec_event <= ev;
		{sys_n, par_n, par_en} <= pins;
		@(posedge core_clk);
		sec_event <= '0;
		{sys_n, par_n, par_en} <= 3'b110;
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		rd(8'h1c, 32'h02a0_0100);
		$display("test reset values done");
		for (int i = 0; i < 10; i++) begin
			fire(ev_tab[i], pin_tab[i]);
			rd(8'h1c, {16'h02a0 | exp_tab[i], 16'h0100});
			config_host_i.cfg_write(8'h1c, 4'b0011, 32'h0000_0000);
			rd(8'h1c, {16'h02a0 | exp_tab[i], 16'h0100});
			config_host_i.cfg_write(8'h1c, 4'b0011, 32'hffff_0000);
			rd(8'h1c, 32'h02a0_0100);
		end
		// Event and clearing write in the same cycle
		fork
			fire(7'h40, 3'b110);
			config_host_i.cfg_write(8'h1c, 4'b0011, 32'hffff_0000);
		join
		rd(8'h1c, 32'h82a0_0100);
		config_host_i.cfg_write(8'h1c, 4'b0011, 32'hffff_0000);
		rd(8'h1c, 32'h02a0_0100);
		$display("test status flags done");
		config_host_i.cfg_write(8'h1c, 4'b0000, 32'hffff_ffff);
		rd(8'h1c, 32'h02a0_f100);
		config_host_i.cfg_write(8'h1c, 4'b1101, 32'h0000_0000);
		rd(8'h1c, 32'h02a0_0100);
		config_host_i.cfg_write(8'h1c, 4'b0010, 32'h0000_f000);
		rd(8'h1c, 32'h02a0_0100);
		config_host_i.cfg_write(8'h18, 4'b0000, 32'hffff_ffff);
		rd(8'h1c, 32'h02a0_0100);
		rd(8'h18, 32'h0000_0000);
		$display("test byte lanes done");
		config_host_i.cfg_write(8'h1c, 4'b1101, 32'h0000_4000);
		repeat (2) @(posedge core_clk);
		#1 check({28'h0, field}, 32'h0000_0004);
		check(top_addr, 32'h0001_4000);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			query <= q_tab[i];
			repeat (2) @(posedge core_clk);
			#1 check({31'h0, hit}, {31'h0, hit_tab[i]});
		end
		@(posedge core_clk);
		upper <= 16'h00a5;
		repeat (2) @(posedge core_clk);
		#1 check(top_addr, 32'h00a5_4000);
		$display("test forwarding window done");
		complete_run();
	end
endmodule
